/* core/clock_trim_pkg.sv */
// package: register map, reset values and timing counts of the clock trim
package clock_trim_pkg;

	// register offsets as printed
	localparam logic [7:0]  SAMPLE_CLK_CFG_OFS  = 8'h4b;
	localparam logic [7:0]  TIMING_CLK_TRIM_OFS = 8'h4d;
	localparam logic [7:0]  CONV_CLK_SEL_OFS    = 8'h4e;

	// reset values, reserved fields included
	localparam logic [15:0] SAMPLE_CLK_CFG_RST  = 16'h2612;
	localparam logic [15:0] TIMING_CLK_TRIM_RST = 16'h425e;
	localparam logic [15:0] CONV_CLK_SEL_RST    = 16'h0060;
	localparam logic [15:0] UNMAPPED_RDATA      = 16'h0000;

	// field positions in sample_clock_config; the fast trim MSB is in the timing trim register
	localparam int          OSC_BYPASS_BIT      = 8;
	localparam int          SAMPLE_EN_BIT       = 7;
	localparam int          SLOW_TRIM_MSB       = 5;
	localparam int          FAST_TRIM_MSB       = 7;

	// trim meaning: slow is inverse, fast is direct
	localparam logic [5:0]  SLOW_TRIM_FASTEST   = 6'h00;
	localparam logic [5:0]  SLOW_TRIM_CENTRE    = 6'h22;
	localparam logic [5:0]  SLOW_TRIM_SLOWEST   = 6'h3f;
	localparam int          SLOW_STEP_HZ        = 600;
	localparam int          FAST_STEP_HZ        = 109_000;

	// converter clock codes
	localparam logic [15:0] CONV_SEL_1MHZ       = 16'h0040;
	localparam logic [15:0] CONV_SEL_500KHZ     = 16'h0060;

	// timing counts derived from the system clock
	localparam int          CLK_HZ              = 100_000_000;
	localparam int          CONV_FAST_HZ        = 1_000_000;
	localparam int          CONV_SLOW_HZ        = 500_000;
	localparam logic [7:0]  CONV_FAST_DIV       = 8'(CLK_HZ / CONV_FAST_HZ);
	localparam logic [7:0]  CONV_SLOW_DIV       = 8'(CLK_HZ / CONV_SLOW_HZ);

	// register port request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} reg_req_t;

endpackage

/* core/clock_trim.sv */
// clock trim: sample clock source, oscillator trims, converter clock rate
module clock_trim
(
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	input  wire clock_trim_pkg::reg_req_t reg_req,
	output logic [15:0]                   reg_rdata,
	output logic                          reg_rvalid,
	input  wire logic                     slow_osc_tick,
	input  wire logic                     photo_sync_pin,
	input  wire logic                     integration_mode,
	output logic                          sample_tick,
	output logic                          sample_clock_running,
	output logic [5:0]                    slow_osc_trim,
	output logic [7:0]                    fast_osc_trim,
	output logic                          conv_tick,
	output logic                          conv_fast
);
	import clock_trim_pkg::*;

	logic [15:0] sample_cfg_q;
	logic [15:0] timing_trim_q;
	logic [15:0] conv_sel_q;
	logic [15:0] rdata_q;
	logic        rvalid_q;
	logic        sync_prev_q;
	logic [7:0]  div_q;
	logic [7:0]  div_d;

	// address decode
	wire         hit_sample = reg_req.addr == SAMPLE_CLK_CFG_OFS;
	wire         hit_timing = reg_req.addr == TIMING_CLK_TRIM_OFS;
	wire         hit_conv   = reg_req.addr == CONV_CLK_SEL_OFS;
	wire         wr_sample  = reg_req.wr && hit_sample;
	wire         wr_timing  = reg_req.wr && hit_timing;
	wire         wr_conv    = reg_req.wr && hit_conv;

	// read mux; unmapped offsets answer zero
	wire  [15:0] rdata_d    = hit_sample ? sample_cfg_q  :
	                          hit_timing ? timing_trim_q :
	                          hit_conv   ? conv_sel_q    : UNMAPPED_RDATA;

	// control fields
	wire         osc_bypass = sample_cfg_q[OSC_BYPASS_BIT];
	wire         sample_en  = sample_cfg_q[SAMPLE_EN_BIT];
	wire         sync_rise  = photo_sync_pin && !sync_prev_q;

	// register file; reserved bits are stored as written
	// config, trim and converter code storage
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sample_cfg_q  <= SAMPLE_CLK_CFG_RST;
			timing_trim_q <= TIMING_CLK_TRIM_RST;
			conv_sel_q    <= CONV_CLK_SEL_RST;
		end else begin
			if (wr_sample)
				sample_cfg_q <= reg_req.wdata;
			if (wr_timing)
				timing_trim_q <= reg_req.wdata;
			// illegal codes are kept but run at the slow rate
			if (wr_conv)
				conv_sel_q <= reg_req.wdata;
		end
	end

	// read data is registered, one cycle after the strobe
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q  <= 16'h0000;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= reg_req.rd;
			if (reg_req.rd)
				rdata_q <= rdata_d;
		end
	end

	assign reg_rdata  = rdata_q;
	assign reg_rvalid = rvalid_q;

	// edge memory for the external sample clock
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			sync_prev_q <= 1'b0;
		else
			sync_prev_q <= photo_sync_pin;
	end

	// sample clock source select and gate
	// source mux
	wire         src_tick   = osc_bypass ? sync_rise : slow_osc_tick;
	assign sample_tick          = sample_en && src_tick;
	assign sample_clock_running = sample_en;

	// trims go straight to the analog oscillators; the analog side does
	// the frequency law, so code order here must not be remapped
	// slow and fast trim drive
	assign slow_osc_trim = sample_cfg_q[SLOW_TRIM_MSB:0];
	assign fast_osc_trim = timing_trim_q[FAST_TRIM_MSB:0];

	// converter rate; outside integration mode the slow rate is used
	// rate choice
	assign conv_fast = integration_mode && (conv_sel_q == CONV_SEL_1MHZ);
	wire   [7:0] div_limit = conv_fast ? CONV_FAST_DIV : CONV_SLOW_DIV;
	// >= so a switch to the faster rate mid-count cannot overrun
	assign conv_tick = div_q >= (div_limit - 8'h01);
	assign div_d     = conv_tick ? 8'h00 : div_q + 8'h01;

	// converter clock enable divider
	// divider
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			div_q <= 8'h00;
		else
			div_q <= div_d;
	end

	// bypass path follows the pin edge
	// external source
	byp_src_a: assert property (@(posedge clk) disable iff (sys_rst)
		(sample_en && osc_bypass && photo_sync_pin && !sync_prev_q)
		|-> sample_tick)
		else $error("bypassed sample tick missing");

	// internal oscillator ignored while bypassed
	// bypass isolation
	byp_iso_a: assert property (@(posedge clk) disable iff (sys_rst)
		(osc_bypass && !sync_rise) |-> !sample_tick)
		else $error("internal tick leaked in bypass");

	// stopped clock gives no ticks
	// stop check
	clk_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
		!sample_cfg_q[SAMPLE_EN_BIT] |-> !sample_tick)
		else $error("sample tick while disabled");

	// internal path passes osc ticks
	// internal source
	int_src_a: assert property (@(posedge clk) disable iff (sys_rst)
		(sample_en && !osc_bypass && slow_osc_tick) |-> sample_tick)
		else $error("internal sample tick missing");

	// slow trim write reaches the oscillator
	// slow trim write
	slow_trim_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_req.wr && reg_req.addr == SAMPLE_CLK_CFG_OFS)
		|=> slow_osc_trim == $past(reg_req.wdata[5:0]))
		else $error("slow trim not updated");

	// fast trim write reaches the oscillator
	// fast trim write
	fast_trim_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_req.wr && reg_req.addr == TIMING_CLK_TRIM_OFS)
		|=> fast_osc_trim == $past(reg_req.wdata[7:0]))
		else $error("fast trim not updated");

	// fast rate only in integration mode with the 1 MHz code
	// mode gate
	conv_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
		conv_fast |-> (integration_mode && conv_sel_q == CONV_SEL_1MHZ))
		else $error("fast converter rate outside mode");

	// converter ticks are spaced by the divider
	// tick spacing
	conv_gap_a: assert property (@(posedge clk) disable iff (sys_rst)
		conv_tick |=> (!conv_tick)[*8] ##0 (div_q == 8'h07))
		else $error("converter ticks too close");

	// slow rate terminal count is 200 cycles
	// slow period
	conv_slow_a: assert property (@(posedge clk) disable iff (sys_rst)
		(conv_tick && !conv_fast) |-> div_q == (CONV_SLOW_DIV - 8'h01))
		else $error("slow converter period wrong");

	// reads of an unmapped offset answer zero
	// unmapped read
	unmap_rd_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_req.rd && !hit_sample && !hit_timing && !hit_conv)
		|=> (reg_rvalid && reg_rdata == UNMAPPED_RDATA))
		else $error("unmapped read not zero");

	// read answers next cycle with the value before any same-cycle write
	// read data
	rd_data_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_req.rd && hit_sample)
		|=> (reg_rvalid && reg_rdata == $past(sample_cfg_q)))
		else $error("config read data wrong");

	// no answer without a strobe the cycle before
	// single answer
	rd_once_a: assert property (@(posedge clk) disable iff (sys_rst)
		!reg_req.rd |=> !reg_rvalid)
		else $error("read answer without strobe");

	// steady fast rate ends each count at 100 cycles; the switch cycle may
	// end early because the count can already be past the new limit
	// fast period
	fast_per_a: assert property (@(posedge clk) disable iff (sys_rst)
		(conv_tick && conv_fast && $past(conv_fast))
		|-> div_q == (CONV_FAST_DIV - 8'h01))
		else $error("fast converter period wrong");

	// first edge after reset still shows the reset slow trim
	// slow reset
	rst_slow_a: assert property (@(posedge clk) disable iff (sys_rst)
		$past(sys_rst)
		|-> slow_osc_trim == SAMPLE_CLK_CFG_RST[SLOW_TRIM_MSB:0])
		else $error("slow trim reset value wrong");

	// first edge after reset still shows the reset fast trim
	// fast reset
	rst_fast_a: assert property (@(posedge clk) disable iff (sys_rst)
		$past(sys_rst)
		|-> fast_osc_trim == TIMING_CLK_TRIM_RST[FAST_TRIM_MSB:0])
		else $error("fast trim reset value wrong");

endmodule // clock_trim

/* verif/tb_top.sv */
// testbench: register port, sample clock source and converter rate
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
	$display("ERROR %0t: got %h want %h", $time, a, b); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import clock_trim_pkg::*;
	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic [15:0] exp;
		logic [5:0]  t6;
		logic [7:0]  t8;
	} row_t;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        slow_osc_tick = 1'b0;
	logic        photo_sync_pin = 1'b0;
	logic        integration_mode = 1'b0;
	reg_req_t    req = '0;
	logic [15:0] reg_rdata;
	logic        reg_rvalid, sample_tick, sample_clock_running;
	logic        conv_tick, conv_fast;
	logic [5:0]  slow_osc_trim;
	logic [7:0]  fast_osc_trim;
	int          errors = 0;
	int          check_count = 0;
	int          p;
	// writes with read-back; last row hits an unmapped offset
	// legal codes only
	row_t rows [6] = '{
		'{8'h4b, 16'h2680, 16'h2680, 6'h00, 8'h5e},
		'{8'h4b, 16'h26bf, 16'h26bf, 6'h3f, 8'h5e},
		'{8'h4d, 16'h42ff, 16'h42ff, 6'h3f, 8'hff},
		'{8'h4d, 16'h4200, 16'h4200, 6'h3f, 8'h00},
		'{8'h4e, 16'h0040, 16'h0040, 6'h3f, 8'h00},
		'{8'h4c, 16'hffff, 16'h0000, 6'h3f, 8'h00}};
	clock_trim i_dut (.clk(clk), .sys_rst(sys_rst), .reg_req(req),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.slow_osc_tick(slow_osc_tick), .photo_sync_pin(photo_sync_pin),
		.integration_mode(integration_mode), .sample_tick(sample_tick),
		.sample_clock_running(sample_clock_running),
		.slow_osc_trim(slow_osc_trim), .fast_osc_trim(fast_osc_trim),
		.conv_tick(conv_tick), .conv_fast(conv_fast));
	// free running 100 MHz clock
	always #5 clk = ~clk;
	task report_and_stop;
		if (errors == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// one-cycle strobes, always launched at a falling edge
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk); req.wr = 1'b1; req.addr = a; req.wdata = d;
		@(negedge clk); req.wr = 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [15:0] e);
		@(negedge clk); req.rd = 1'b1; req.addr = a;
		@(negedge clk); req.rd = 1'b0;
		`CHK(reg_rvalid, 1'b1) // answer
		`CHK(reg_rdata, e) // read data
	endtask
	// ticks are combinational, so look just after the input moves
	task tick_chk(input logic e);
		@(negedge clk); slow_osc_tick = 1'b1;
		#1 `CHK(sample_tick, e) // osc tick
		@(negedge clk); slow_osc_tick = 1'b0;
	endtask
	task pin_chk(input logic e);
		@(negedge clk); photo_sync_pin = 1'b1;
		#1 `CHK(sample_tick, e) // edge tick
		@(negedge clk);
		`CHK(sample_tick, 1'b0) // one tick
		photo_sync_pin = 1'b0;
	endtask
	// first whole gap between ticks; the count up to the first tick may straddle a rate change
	task period(output int c);
		repeat (2) begin
			c = 0;
			do begin @(negedge clk); c++; end while (!conv_tick && c < 400);
		end
	endtask
	initial begin
		repeat (20) @(negedge clk);
		sys_rst = 1'b0;
		// reset values
		`CHK(slow_osc_trim, 6'h12) // slow trim
		`CHK(fast_osc_trim, 8'h5e) // fast trim
		`CHK(sample_clock_running, 1'b0) // clock off
		rd(CONV_CLK_SEL_OFS, 16'h0060); // converter code
		rd(SAMPLE_CLK_CFG_OFS, 16'h2612); // config word
		rd(TIMING_CLK_TRIM_OFS, 16'h425e); // trim word
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr, rows[i].exp); // read back
			`CHK(slow_osc_trim, rows[i].t6) // slow code
			`CHK(fast_osc_trim, rows[i].t8) // fast code
		end
		// source and enable combinations
		wr(8'h4b, 16'h2622);
		`CHK(sample_clock_running, 1'b0) // stopped
		tick_chk(1'b0); // no tick
		pin_chk(1'b0); // no tick
		wr(8'h4b, 16'h26a2);
		`CHK(sample_clock_running, 1'b1) // running
		tick_chk(1'b1); // internal source
		pin_chk(1'b0); // pin ignored
		wr(8'h4b, 16'h27a2);
		tick_chk(1'b0); // oscillator bypassed
		pin_chk(1'b1); // pin source
		wr(8'h4b, 16'h2722);
		pin_chk(1'b0); // bypass but off
		// converter rate against mode
		@(negedge clk); integration_mode = 1'b1; #1
		`CHK(conv_fast, 1'b1) // fast code
		period(p);
		`CHK(p, 100) // 1 MHz gap
		@(negedge clk); integration_mode = 1'b0; #1
		`CHK(conv_fast, 1'b0) // mode off
		period(p);
		`CHK(p, 200) // 500 kHz gap
		integration_mode = 1'b1;
		wr(CONV_CLK_SEL_OFS, CONV_SEL_500KHZ);
		`CHK(conv_fast, 1'b0) // slow code
		period(p);
		`CHK(p, 200) // 500 kHz gap
		// mid-run reset puts written fields back
		wr(CONV_CLK_SEL_OFS, CONV_SEL_1MHZ);
		@(negedge clk); sys_rst = 1'b1;
		#1 `CHK(slow_osc_trim, 6'h12) // slow trim
		`CHK(fast_osc_trim, 8'h5e) // fast trim
		`CHK(conv_fast, 1'b0) // reset code
		@(negedge clk); sys_rst = 1'b0;
		rd(CONV_CLK_SEL_OFS, 16'h0060); // converter code
		rd(SAMPLE_CLK_CFG_OFS, 16'h2612); // config word
		report_and_stop;
	end
	// watchdog well past the expected run
	initial begin
		#100us;
		errors++;
		report_and_stop;
	end
endmodule // tb_top
